// file: hdl/scdr_consts.svh
// Constants of the safety command and diagnostic register bank.
// Assumes a 250 MHz core clock and 20-bit SPI data fields.
`ifndef SCDR_CONSTS_SVH
`define SCDR_CONSTS_SVH
`define SCDR_ADDR_SAFING    7'h31
`define SCDR_ADDR_RECOVER   7'h32
`define SCDR_ADDR_SEED      7'h33
`define SCDR_ADDR_KEY       7'h34
`define SCDR_ADDR_WDTEST    7'h35
`define SCDR_ADDR_OUTSEL    7'h36
`define SCDR_ADDR_LOOPRES   7'h37
`define SCDR_SAFING_PATTERN 16'hACAC
`define SCDR_WDTEST_PATTERN 8'h3C
`define SCDR_PREV_KEY_RST   8'h0D
`define SCDR_SEED_RST       8'hF0
`define SCDR_OUTSEL_RST     4'h0
`define SCDR_PULSE_MS       8
`define SCDR_CLK_KHZ        250000
`define SCDR_PULSE_CYC      (`SCDR_PULSE_MS * `SCDR_CLK_KHZ)
`define SCDR_LVL_POS        19
`define SCDR_TIP_POS        18
`define SCDR_FP_POS         16
`define SCDR_FET_ON_FLAG_POS      15
`define SCDR_DRVOK_POS      14
`define SCDR_HI_POS         13
`define SCDR_LO_POS         12
`define SCDR_RCH_LSB        8
`define SCDR_SBL_POS        7
`define SCDR_STG_POS        6
`define SCDR_STB_POS        5
`define SCDR_SQP_POS        4
`define SCDR_LCH_LSB        0
`endif

// file: hdl/scdr_pkg.sv
// Types of the safety command and diagnostic register bank.
// Assumes the constants header is compiled alongside.
package scdr_pkg;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [6:0] addr;
    logic [19:0] data;
  } scdr_req_t;
  // Result inputs from the loop sequencer and analog checks
  typedef struct packed {
    logic       test_in_progress;
    logic       prior_fault;
    logic       fet_on;
    logic       path_ok_upd;
    logic       path_ok;
    logic       res_upd;
    logic       res_hi;
    logic       res_lo;
    logic [3:0] res_ch;
    logic       loop_short_upd;
    logic       loop_short;
    logic       leak_upd;
    logic       gnd_short;
    logic       bat_short;
    logic       leak_pin;
    logic [3:0] leak_ch;
    logic [3:0] high_diagnostic_state;
  } scdr_loop_t;
  typedef struct packed {
    logic [3:0] arm;
    logic       inhibit_release;
    logic       safing_reg_en;
    logic       hs_fet_on;
    logic       ls_fet_on;
  } scdr_outs_t;
  typedef enum logic [2:0] {
    SCDR_PT_IDLE = 3'b001,
    SCDR_PT_HIGH = 3'b010,
    SCDR_PT_WAIT = 3'b100
  } scdr_pt_t;
endpackage : scdr_pkg

// file: hdl/scdr_pulse_gen.sv
// Deployment timing pulse generator on the first arming pin.
// Assumes i_en is a level from logic on the same clock.
`timescale 1ns/1ps
module scdr_pulse_gen
  import scdr_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = 2000000
)(
  input  wire logic i_core_clk,
  input  wire logic i_srst,
  input  wire logic i_en,
  output logic      o_pulse
);
  initial
  begin
    if (PERIOD_CYC < 2)
      $error("PERIOD_CYC too small");
  end
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  scdr_pt_t    st_ff;
  scdr_pt_t    nxt_st;
  logic        wrap;
  assign wrap    = (cnt_ff == 32'(PERIOD_CYC - 1));
  // Count restarts at the first pulse so every gap is one full period
  assign nxt_cnt = (!i_en || wrap || st_ff == SCDR_PT_IDLE) ? 32'h0 : cnt_ff + 32'h1;
  always_comb
  begin
    case (st_ff)
      SCDR_PT_IDLE: nxt_st = i_en ? SCDR_PT_HIGH : SCDR_PT_IDLE;
      SCDR_PT_HIGH: nxt_st = !i_en ? SCDR_PT_IDLE : SCDR_PT_WAIT;
      SCDR_PT_WAIT: nxt_st = !i_en ? SCDR_PT_IDLE : (wrap ? SCDR_PT_HIGH : SCDR_PT_WAIT);
      default:      nxt_st = SCDR_PT_IDLE;
    endcase
  end
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      cnt_ff <= 32'h0;
      st_ff  <= SCDR_PT_IDLE;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      st_ff  <= nxt_st;
    end
  end
  // One-cycle pulse every period while enabled
  assign o_pulse = (st_ff == SCDR_PT_HIGH);
endmodule : scdr_pulse_gen

// file: hdl/scdr_regs.sv
// Command and diagnostic register bank behind the SPI frame decoder.
// Assumes a decoded request per frame; watchdogs and sequencer outside.
`timescale 1ns/1ps
`include "scdr_consts.svh"
// Contract
// - Pattern ACAC written at 0x31 moves diagnostic state to safing; not stored.
// - Safing command in diagnostic or safing state clears arming stretch counter.
// - Recover command at 0x32 clears second watchdog retries in lock state.
// - Seed read upper byte returns previous key, reset value 0x0D.
// - Seed read lower byte is sampled free-running counter, reset 0xF0.
// - Test command carries 3C patterns for both watchdogs as events.
// - Output test selector writable only in diagnostic state; cleared by reset.
// - Codes 1-8 drive arming pins, inhibit release, regulator, FETs.
// - Code 1001 emits timing pulses on first arming pin every 8 ms.
// - Code 1010 drives high-side FET until current comparator trips.
// - Level bit mirrors last level written to loop request register.
// - Test-in-progress bit is 1 while high-level diagnostic runs.
// - Prior-fault bit set when fault existed before diagnostic.
// - FET-on bit set by FET activation in diagnostic state or sequencer.
// - Driver-ok bit reports full-path test success.
// - Resistance high and low flags report threshold comparison.
// - Loop-short flag set when sequencer finds short between loops.
// - Leakage test updates ground and battery short flags.
// - Pin-select bit reports return pin 0 or feed pin 1.
// - Channel fields encode 0 to B; 1100 to 1111 means none.
module scdr_regs
  import scdr_pkg::*;
#(
  parameter int unsigned PULSE_CYC = `SCDR_PULSE_CYC
)(
  input  wire logic       i_core_clk,
  input  wire logic       i_srst,
  input  wire scdr_req_t  i_req,
  output logic [19:0]     o_rdata,
  input  wire logic       i_diagnostic_state_state,
  input  wire logic       i_safing_state,
  input  wire logic       i_wd_two_lock,
  input  wire logic       i_system_state_reset,
  input  wire logic       i_loop_req_wr,
  input  wire logic       i_loop_req_level,
  input  wire scdr_loop_t i_loop,
  input  wire logic       i_current_trip,
  output logic            o_enter_safing,
  output logic            o_clear_arm_stretch,
  output logic            o_wd_two_retry_clear,
  output logic            o_key_valid,
  output logic [7:0]      o_key_value,
  output logic            o_first_watchdog_test_cmd,
  output logic            o_second_watchdog_test_cmd,
  output scdr_outs_t      o_outs
);
  initial
  begin
    if (PULSE_CYC < 2)
      $error("PULSE_CYC too small");
  end

  // ==========================================================
  // Request decode
  function automatic logic hit(input scdr_req_t r, input logic [6:0] a);
    hit = r.valid && (r.addr == a);
  endfunction : hit

  logic wr_safing;
  logic wr_recover;
  logic wr_key;
  logic wr_wdtest;
  logic wr_outsel;
  logic ssr;
  assign ssr        = i_srst || i_system_state_reset;
  assign wr_safing  = hit(i_req, `SCDR_ADDR_SAFING) && i_req.write;
  assign wr_recover = hit(i_req, `SCDR_ADDR_RECOVER) && i_req.write;
  assign wr_key     = hit(i_req, `SCDR_ADDR_KEY) && i_req.write;
  assign wr_wdtest  = hit(i_req, `SCDR_ADDR_WDTEST) && i_req.write;
  assign wr_outsel  = hit(i_req, `SCDR_ADDR_OUTSEL) && i_req.write;

  // ==========================================================
  // Command pulses
  logic safing_ok;
  assign safing_ok = wr_safing && (i_req.data[15:0] == `SCDR_SAFING_PATTERN);
  logic enter_ff;
  logic clr_ff;
  logic recover_ff;
  logic key_v_ff;
  logic [7:0] key_ff;
  logic t1_ff;
  logic t2_ff;
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      enter_ff   <= 1'b0;
      clr_ff     <= 1'b0;
      recover_ff <= 1'b0;
      key_v_ff   <= 1'b0;
      key_ff     <= 8'h00;
      t1_ff      <= 1'b0;
      t2_ff      <= 1'b0;
    end
    else
    begin
      enter_ff   <= safing_ok && i_diagnostic_state_state;
      clr_ff     <= safing_ok && (i_diagnostic_state_state || i_safing_state);
      recover_ff <= wr_recover && i_wd_two_lock;
      key_v_ff   <= wr_key;
      key_ff     <= wr_key ? i_req.data[7:0] : key_ff;
      t1_ff      <= wr_wdtest && (i_req.data[15:8] == `SCDR_WDTEST_PATTERN);
      t2_ff      <= wr_wdtest && (i_req.data[7:0] == `SCDR_WDTEST_PATTERN);
    end
  end
  assign o_enter_safing       = enter_ff;
  assign o_clear_arm_stretch  = clr_ff;
  assign o_wd_two_retry_clear = recover_ff;
  assign o_key_valid          = key_v_ff;
  assign o_key_value          = key_ff;
  assign o_first_watchdog_test_cmd      = t1_ff;
  assign o_second_watchdog_test_cmd     = t2_ff;

  // ==========================================================
  // Seed and previous key
  logic [7:0] free_ff;
  logic [7:0] prev_key_ff;
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      free_ff     <= `SCDR_SEED_RST;
      prev_key_ff <= `SCDR_PREV_KEY_RST;
    end
    else
    begin
      free_ff     <= free_ff + 8'h01;
      prev_key_ff <= wr_key ? i_req.data[7:0] : prev_key_ff;
    end
  end

  // ==========================================================
  // Output test selector
  logic [3:0] sel_ff;
  always_ff @(posedge i_core_clk)
  begin
    if (ssr)
      sel_ff <= `SCDR_OUTSEL_RST;
    else if (wr_outsel && i_diagnostic_state_state)
      sel_ff <= i_req.data[3:0];
  end

  logic pulse;
  scdr_pulse_gen #(
    .PERIOD_CYC (PULSE_CYC)
  ) u_pulse (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_en       (sel_ff == 4'h9),
    .o_pulse    (pulse)
  );

  // Full-path test: FET held until comparator trips
  logic fp_arm_ff;
  logic fp_done_ff;
  logic fp_ok_ff;
  logic fp_on;
  assign fp_on = (sel_ff == 4'hA) && !fp_done_ff;
  always_ff @(posedge i_core_clk)
  begin
    if (ssr || sel_ff != 4'hA)
    begin
      fp_done_ff <= 1'b0;
      fp_ok_ff   <= 1'b0;
      fp_arm_ff  <= 1'b0;
    end
    else
    begin
      fp_arm_ff <= 1'b1;
      if (fp_arm_ff && i_current_trip && !fp_done_ff)
      begin
        fp_done_ff <= 1'b1;
        fp_ok_ff   <= 1'b1;
      end
    end
  end

  scdr_outs_t outs_ff;
  scdr_outs_t nxt_outs;
  always_comb
  begin
    nxt_outs = '0;
    case (sel_ff)
      4'h1: nxt_outs.arm[0]          = 1'b1;
      4'h2: nxt_outs.arm[1]          = 1'b1;
      4'h3: nxt_outs.arm[2]          = 1'b1;
      4'h4: nxt_outs.arm[3]          = 1'b1;
      4'h5: nxt_outs.inhibit_release = 1'b1;
      4'h6: nxt_outs.safing_reg_en   = 1'b1;
      4'h7: nxt_outs.hs_fet_on       = 1'b1;
      4'h8: nxt_outs.ls_fet_on       = 1'b1;
      4'h9: nxt_outs.arm[0]          = pulse;
      4'hA: nxt_outs.hs_fet_on       = fp_on && !i_current_trip;
      default: nxt_outs = '0;
    endcase
  end
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      outs_ff <= '0;
    else
      outs_ff <= nxt_outs;
  end
  assign o_outs = outs_ff;

  // ==========================================================
  // Loop result register
  logic       lvl_ff;
  logic       fet_ff;
  logic       drv_ok_ff;
  logic       hi_ff;
  logic       lo_ff;
  logic       sbl_ff;
  logic       stg_ff;
  logic       stb_ff;
  logic       sqp_ff;
  logic [3:0] rch_ff;
  logic [3:0] lch_ff;
  logic       fet_set;
  assign fet_set = i_loop.fet_on
                 || (i_diagnostic_state_state && (outs_ff.hs_fet_on || outs_ff.ls_fet_on));
  always_ff @(posedge i_core_clk)
  begin
    if (ssr)
    begin
      lvl_ff    <= 1'b0;
      // Sticky flags: a set in a system state reset cycle wins
      fet_ff    <= fet_set && !i_srst;
      drv_ok_ff <= 1'b0;
      hi_ff     <= 1'b0;
      lo_ff     <= 1'b0;
      sbl_ff    <= i_loop.loop_short_upd && i_loop.loop_short && !i_srst;
      stg_ff    <= 1'b0;
      stb_ff    <= 1'b0;
      sqp_ff    <= 1'b0;
      rch_ff    <= 4'h0;
      lch_ff    <= 4'h0;
    end
    else
    begin
      if (i_loop_req_wr)
        lvl_ff <= i_loop_req_level;
      if (fet_set)
        fet_ff <= 1'b1;
      if (sel_ff == 4'hA)
        drv_ok_ff <= fp_ok_ff;
      else if (i_loop.path_ok_upd)
        drv_ok_ff <= i_loop.path_ok;
      if (i_loop.res_upd)
      begin
        hi_ff  <= i_loop.res_hi;
        lo_ff  <= i_loop.res_lo;
        rch_ff <= i_loop.res_ch;
      end
      if (i_loop.loop_short_upd)
        sbl_ff <= sbl_ff | i_loop.loop_short;
      if (i_loop.leak_upd)
      begin
        stg_ff <= i_loop.gnd_short;
        stb_ff <= i_loop.bat_short;
        sqp_ff <= i_loop.leak_pin;
        lch_ff <= i_loop.leak_ch;
      end
    end
  end

  logic [19:0] loop_word;
  logic [3:0]  mid_field;
  // High-level mode reports selected diagnostic in channel field
  assign mid_field = lvl_ff ? i_loop.high_diagnostic_state : rch_ff;
  assign loop_word = {lvl_ff,
                      i_loop.test_in_progress && lvl_ff,
                      1'b0,
                      i_loop.prior_fault,
                      fet_ff, drv_ok_ff, hi_ff, lo_ff,
                      mid_field,
                      sbl_ff, stg_ff, stb_ff, sqp_ff,
                      lch_ff};

  // ==========================================================
  // Read data
  logic [19:0] nxt_rdata;
  logic [19:0] rdata_ff;
  always_comb
  begin
    nxt_rdata = 20'h00000;
    if (i_req.valid)
    begin
      case (i_req.addr)
        `SCDR_ADDR_SEED:    nxt_rdata = {4'h0, prev_key_ff, free_ff};
        `SCDR_ADDR_OUTSEL:  nxt_rdata = {16'h0000, sel_ff};
        `SCDR_ADDR_LOOPRES: nxt_rdata = loop_word;
        default:            nxt_rdata = 20'h00000;
      endcase
    end
  end
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      rdata_ff <= 20'h00000;
    else if (i_req.valid)
      rdata_ff <= nxt_rdata;
  end
  assign o_rdata = rdata_ff;
endmodule : scdr_regs

// file: testbench/scdr_mcu_model.sv
// Controller-side model issuing one decoded frame per call.
// Assumes the bank samples requests on the rising clock edge.
`timescale 1ns/1ps
module scdr_mcu_model
  import scdr_pkg::*;
(
  input  wire logic i_core_clk,
  output scdr_req_t o_req
);
  // ==========
  // Frames
  initial o_req = '0;
  // Released fields show inverted values
  task automatic xfer(input logic w, input logic [6:0] a, input logic [19:0] d);
    @(posedge i_core_clk);
    #1 o_req = '{valid: 1'b1, write: w, addr: a, data: d};
    @(posedge i_core_clk);
    #1 o_req = '{valid: 1'b0, write: ~w, addr: ~a, data: ~d};
  endtask : xfer
  task automatic send_key(input logic [19:0] s);
    xfer(1'b1, 7'h34, {12'h000, (s[7:0] ^ s[15:8]) + 8'h01});
  endtask : send_key
endmodule : scdr_mcu_model

// file: testbench/scdr_regs_monitor.sv
// Port checks for the command and result register bank.
// Assumes one core clock and a synchronous reset.
`timescale 1ns/1ps
module scdr_regs_monitor
  import scdr_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_srst,
  input wire scdr_req_t   i_req,
  input wire logic [19:0] o_rdata,
  input wire logic        i_diagnostic_state_state,
  input wire logic        i_safing_state,
  input wire logic        i_wd_two_lock,
  input wire logic        i_system_state_reset,
  input wire logic        i_loop_req_wr,
  input wire logic        i_loop_req_level,
  input wire logic        o_enter_safing,
  input wire logic        o_clear_arm_stretch,
  input wire logic        o_wd_two_retry_clear,
  input wire logic        o_key_valid,
  input wire logic [7:0]  o_key_value,
  input wire logic        o_first_watchdog_test_cmd,
  input wire logic        o_second_watchdog_test_cmd
);
  // ==========
  // Decode
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);
  logic       lvl_ff;
  wire  [6:0] a   = i_req.addr;
  wire        wr  = i_req.valid & i_req.write;
  wire        saf = wr & (a == 7'h31) & (i_req.data[15:0] == 16'hACAC);
  wire        sdg = saf & i_diagnostic_state_state;
  wire  [7:0] kd  = i_req.data[7:0];
  wire        t1c = i_req.data[15:8] == 8'h3C;
  wire        t2c = kd == 8'h3C;
  wire        wo  = i_req.valid & (a == 7'h31 | a == 7'h32 | a == 7'h34 | a == 7'h35);
  wire        rdl = i_req.valid & ~i_req.write & (a == 7'h37);
  // Last level written to the loop request register
  always_ff @(posedge i_core_clk)
    if (i_srst | i_system_state_reset)
      lvl_ff <= 1'b0;
    else if (i_loop_req_wr)
      lvl_ff <= i_loop_req_level;
  // ==========
  // Checks
  a_safing_enter_fwd: assert property (sdg |=> o_enter_safing)
    else $error("safing entry missing");
  a_safing_enter_only: assert property (o_enter_safing |-> $past(sdg))
    else $error("safing entry without command");
  a_stretch_clear: assert property (saf & (i_diagnostic_state_state | i_safing_state)
    |=> o_clear_arm_stretch) else $error("stretch clear missing");
  a_recover_lock: assert property (wr & a == 7'h32 & i_wd_two_lock
    |=> o_wd_two_retry_clear) else $error("retry clear missing");
  a_key_forward: assert property (wr & a == 7'h34
    |=> o_key_valid && o_key_value == $past(kd)) else $error("key not passed");
  a_watchdog_test_cmd_events: assert property (wr & a == 7'h35
    |=> o_first_watchdog_test_cmd == $past(t1c) && o_second_watchdog_test_cmd == $past(t2c))
    else $error("test event wrong");
  a_wo_zero_data: assert property (wo |=> o_rdata == 20'h00000)
    else $error("write-only data not zero");
  a_level_mirror: assert property (rdl |=> o_rdata[19] == $past(lvl_ff))
    else $error("level bit wrong");
endmodule : scdr_regs_monitor

bind scdr_regs scdr_regs_monitor u_mon (
  .i_core_clk           (i_core_clk),
  .i_srst               (i_srst),
  .i_req                (i_req),
  .o_rdata              (o_rdata),
  .i_diagnostic_state_state         (i_diagnostic_state_state),
  .i_safing_state       (i_safing_state),
  .i_wd_two_lock        (i_wd_two_lock),
  .i_system_state_reset (i_system_state_reset),
  .i_loop_req_wr        (i_loop_req_wr),
  .i_loop_req_level     (i_loop_req_level),
  .o_enter_safing       (o_enter_safing),
  .o_clear_arm_stretch  (o_clear_arm_stretch),
  .o_wd_two_retry_clear (o_wd_two_retry_clear),
  .o_key_valid          (o_key_valid),
  .o_key_value          (o_key_value),
  .o_first_watchdog_test_cmd      (o_first_watchdog_test_cmd),
  .o_second_watchdog_test_cmd     (o_second_watchdog_test_cmd)
);

// file: testbench/scdr_regs_tb.sv
// Self-checking bench for the command and result register bank.
// Assumes the controller model and port monitor are compiled first.
`timescale 1ns/1ps
module scdr_regs_tb;
  import scdr_pkg::*;
  logic        i_core_clk = 1'b0;
  logic        i_srst = 1'b1;
  scdr_req_t   i_req;
  logic [19:0] o_rdata;
  logic        i_diagnostic_state_state = 1'b0;
  logic        i_safing_state = 1'b0;
  logic        i_wd_two_lock = 1'b0;
  logic        i_system_state_reset = 1'b0;
  logic        i_loop_req_wr = 1'b0;
  logic        i_loop_req_level = 1'b0;
  scdr_loop_t  i_loop = '0;
  logic        i_current_trip = 1'b0;
  logic        o_enter_safing, o_clear_arm_stretch, o_wd_two_retry_clear;
  logic        o_key_valid, o_first_watchdog_test_cmd, o_second_watchdog_test_cmd;
  logic [7:0]  o_key_value, k;
  scdr_outs_t  o_outs;
  logic [19:0] q;
  int          n_errors = 0, n_tests = 0, n;
  logic [15:0] wt [4] = '{16'h3C3C, 16'h3C00, 16'h003C, 16'h3D3C};
  wire  [4:0]  ev = {o_enter_safing, o_clear_arm_stretch, o_wd_two_retry_clear,
                     o_first_watchdog_test_cmd, o_second_watchdog_test_cmd};
  always #2 i_core_clk = ~i_core_clk;
  scdr_mcu_model mcu (.i_core_clk(i_core_clk), .o_req(i_req));
  scdr_regs #(.PULSE_CYC(20)) dut (
    .i_core_clk           (i_core_clk),
    .i_srst               (i_srst),
    .i_req                (i_req),
    .o_rdata              (o_rdata),
    .i_diagnostic_state_state         (i_diagnostic_state_state),
    .i_safing_state       (i_safing_state),
    .i_wd_two_lock        (i_wd_two_lock),
    .i_system_state_reset (i_system_state_reset),
    .i_loop_req_wr        (i_loop_req_wr),
    .i_loop_req_level     (i_loop_req_level),
    .i_loop               (i_loop),
    .i_current_trip       (i_current_trip),
    .o_enter_safing       (o_enter_safing),
    .o_clear_arm_stretch  (o_clear_arm_stretch),
    .o_wd_two_retry_clear (o_wd_two_retry_clear),
    .o_key_valid          (o_key_valid),
    .o_key_value          (o_key_value),
    .o_first_watchdog_test_cmd      (o_first_watchdog_test_cmd),
    .o_second_watchdog_test_cmd     (o_second_watchdog_test_cmd),
    .o_outs               (o_outs)
  );
  // ==========
  // Tasks
  task automatic tick(input int c);
    repeat (c) @(posedge i_core_clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [19:0] d);
    mcu.xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [6:0] a);
    mcu.xfer(1'b0, a, 20'h00000);
    q = o_rdata;
  endtask : rd
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // ==========
  // Tests
  initial
  begin
    #40000;
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    tick(2);
    i_srst = 1'b0;
    rd(7'h37); chk("res_rst", q, 20'h00000);
    rd(7'h36); chk("sel_rst", q, 20'h00000);
    rd(7'h33); chk("prev_rst", 20'(q[19:8]), 20'h0000D);
    // Seed starts at F0 and has counted five edges since reset
    chk("seed_rst", 20'(q[7:0]), 20'h000F5);
    k = q[7:0];
    rd(7'h33); chk("seed_run", 20'(q[7:0] - k), 20'h00002);
    rd(7'h3F); chk("unmapped", q, 20'h00000);
    i_diagnostic_state_state = 1'b1;
    wr(7'h31, 20'h0ACAC); chk("safing", 20'(ev), 20'h00018);
    chk("wo_zero", o_rdata, 20'h00000);
    wr(7'h31, 20'h0ACAB); chk("bad_pat", 20'(ev), 20'h00000);
    i_diagnostic_state_state = 1'b0;
    i_safing_state = 1'b1;
    wr(7'h31, 20'h0ACAC); chk("in_safing", 20'(ev), 20'h00008);
    i_safing_state = 1'b0;
    wr(7'h31, 20'h0ACAC); chk("no_state", 20'(ev), 20'h00000);
    wr(7'h32, 20'h00000); chk("rec_unlk", 20'(ev), 20'h00000);
    i_wd_two_lock = 1'b1;
    wr(7'h32, 20'h00000); chk("rec_lock", 20'(ev), 20'h00004);
    for (int i = 0; i < 4; i++)
    begin
      wr(7'h35, 20'(wt[i]));
      chk("watchdog_test_cmd", 20'(ev), 20'({wt[i][15:8] == 8'h3C, wt[i][7:0] == 8'h3C}));
    end
    rd(7'h33);
    k = (q[7:0] ^ q[15:8]) + 8'h01;
    mcu.send_key(q); chk("key", 20'({o_key_valid, o_key_value}), 20'({1'b1, k}));
    rd(7'h33); chk("prev_key", 20'(q[19:8]), 20'(k));
    $display("command tests done");
    wr(7'h36, 20'h00001); rd(7'h36); chk("sel_lock", q, 20'h00000);
    i_diagnostic_state_state = 1'b1;
    for (int c = 0; c < 16; c++)
    begin
      if (c == 9 || c == 10)
        continue;
      wr(7'h36, 20'(c));
      tick(1);
      chk("outs", 20'(o_outs), 20'(c >= 1 && c <= 4 ? 8'h10 << (c - 1) :
          c >= 5 && c <= 8 ? 8'h08 >> (c - 5) : 8'h00));
      rd(7'h36); chk("sel", q, 20'(c));
    end
    rd(7'h37); chk("fet_flag", 20'(q[15]), 20'h00001);
    wr(7'h36, 20'h00009);
    n = 0;
    repeat (30)
    begin
      tick(1);
      n += int'(o_outs.arm[0]);
    end
    chk("pulses", 20'(n), 20'h00002);
    wr(7'h36, 20'h0000A); tick(1); chk("hs_on", 20'(o_outs), 20'h00002);
    i_current_trip = 1'b1;
    tick(1); chk("hs_off", 20'(o_outs), 20'h00000);
    tick(2);
    i_current_trip = 1'b0;
    rd(7'h37); chk("drv_ok", 20'(q[14]), 20'h00001);
    i_system_state_reset = 1'b1;
    tick(1);
    i_system_state_reset = 1'b0;
    rd(7'h36); chk("sel_clr", q, 20'h00000);
    rd(7'h37); chk("res_clr", q, 20'h00000);
    $display("selector tests done");
    i_diagnostic_state_state = 1'b0;
    i_loop_req_wr = 1'b1;
    i_loop = '{prior_fault: 1'b1, res_upd: 1'b1, res_hi: 1'b1, res_ch: 4'hB,
               loop_short_upd: 1'b1, loop_short: 1'b1, leak_upd: 1'b1, gnd_short: 1'b1,
               leak_pin: 1'b1, leak_ch: 4'hC, default: '0};
    tick(1);
    i_loop_req_wr = 1'b0;
    i_loop = '{prior_fault: 1'b1, default: '0};
    rd(7'h37); chk("low_res", q, 20'h12BDC);
    i_loop_req_wr = 1'b1;
    i_loop_req_level = 1'b1;
    i_loop = '{test_in_progress: 1'b1, prior_fault: 1'b1, high_diagnostic_state: 4'h6, default: '0};
    tick(1);
    i_loop_req_wr = 1'b0;
    rd(7'h37); chk("high_res", q, 20'hD26DC);
    i_loop_req_wr = 1'b1;
    i_loop_req_level = 1'b0;
    i_loop = '{fet_on: 1'b1, path_ok_upd: 1'b1, path_ok: 1'b1, res_upd: 1'b1, res_lo: 1'b1,
               res_ch: 4'h3, leak_upd: 1'b1, bat_short: 1'b1, leak_ch: 4'h2, default: '0};
    tick(1);
    i_loop_req_wr = 1'b0;
    i_loop = '0;
    rd(7'h37); chk("mixed_res", q, 20'h0D3A2);
    $display("result tests done");
    report_and_stop();
  end
endmodule : scdr_regs_tb
